// ---- hdl/alu_ops_map.svh ----
/*
 * offsets, field positions, reset values and opcode patterns of the
 * add/and execution block.
 * assumes a byte-addressed avalon-mm slave window of 256 bytes.
 */
//**********************************************************************
// Functional notes
// - add accumulator and file, set carry, digit, zero
// - add destination bit low: accumulator, high: file
// - and accumulator with file, only zero flag
// - and-file destination bit picks accumulator or file
// - and literal into accumulator, only zero flag
//**********************************************************************
`ifndef ALU_OPS_MAP_SVH
`define ALU_OPS_MAP_SVH

// register byte offsets
`define ALU_OFS_INSTR      8'h00
`define ALU_OFS_ACC        8'h04
`define ALU_OFS_STATUS     8'h08
`define ALU_FILE_SEL_BIT   7

// status field positions
`define ALU_ST_CARRY       0
`define ALU_ST_DIGIT       1
`define ALU_ST_ZERO        2
`define ALU_ST_UNSUP       3

// reset values
`define ALU_RST_ACC        8'h00
`define ALU_RST_INSTR      12'h000
`define ALU_RST_FILE       8'h00

// instruction word fields
`define ALU_OP6_ADD_FILE   6'h07
`define ALU_OP6_AND_FILE   6'h05
`define ALU_OP4_AND_LIT    4'hE
`define ALU_DEST_BIT       5

`endif

// ---- hdl/alu_ops_pkg.sv ----
/*
 * types shared by the add/and execution block.
 * assumes nothing beyond a systemverilog compiler.
 */
package alu_ops_pkg;

   typedef enum logic [1:0] {
      op_none,
      accumulator_plus_file_op,
      accumulator_mask_file_op,
      accumulator_mask_literal_op
   } op_t;

   typedef struct packed {
      logic [7:0]  acc;
      logic        carry;
      logic        digit_carry_flag;
      logic        zero;
      logic        unsup;
      logic [11:0] last_instr;
      logic        ack;
      logic [31:0] rdata;
   } core_state_t;

endpackage : alu_ops_pkg

// ---- hdl/file_bank.sv ----
/*
 * file register bank: flip-flop storage, one write port, two read ports.
 * assumes writers never collide; reads are combinational from the flops.
 */
`timescale 1ns/1ps
`include "alu_ops_map.svh"
module file_bank #(
   parameter int DEPTH = 32,
   parameter int WIDTH = 8
) (
   input  wire logic                     mclk,     // core clock
   input  wire logic                     rst_n,    // sync reset, active low
   input  wire logic                     wr_en,    // write strobe
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx,   // write index
   input  wire logic [WIDTH-1:0]         wr_data,  // write data
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx_a, // execution read index
   output logic      [WIDTH-1:0]         rd_a,     // execution read data
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx_b, // bus read index
   output logic      [WIDTH-1:0]         rd_b      // bus read data
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
   } bank_state_t;

   bank_state_t s_q;
   bank_state_t s_d;

   generate
      if (DEPTH != 32 || WIDTH != 8) begin : g_bad_geometry
         $error("file_bank: encoding serves 32 registers of 8 bits");
      end
   endgenerate

   assign rd_a = s_q.mem[rd_idx_a];
   assign rd_b = s_q.mem[rd_idx_b];

   always_comb begin
      s_d = s_q;
      if (wr_en) begin
         s_d.mem[wr_idx] = wr_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_q.mem <= {DEPTH{`ALU_RST_FILE}};
      end else begin
         s_q <= s_d;
      end
   end
endmodule : file_bank

// ---- hdl/add_and_alu_ops.sv ----
/*
 * add/and execution datapath with an avalon-mm register slave.
 * a write to the instruction register with both low byte lanes enabled executes that word at once.
 * assumes a master that holds its request until waitrequest is low.
 */
`timescale 1ns/1ps
`include "alu_ops_map.svh"
module add_and_alu_ops (
   input  wire logic        mclk,              // 250 mhz core clock
   input  wire logic        rst_n,             // sync reset, active low
   input  wire logic [7:0]  avs_address,       // byte address
   input  wire logic        avs_read,          // read request
   input  wire logic        avs_write,         // write request
   input  wire logic [31:0] avs_writedata,     // write data
   input  wire logic [3:0]  avs_byteenable,    // byte lanes
   output logic      [31:0] avs_readdata,      // read data, registered
   output logic             avs_waitrequest    // stall, combinational
);
   //*******************************************************************
   // decode helpers
   //*******************************************************************
   function automatic alu_ops_pkg::op_t decode_op(input logic [11:0] iw);
      if (iw[11:6] == `ALU_OP6_ADD_FILE) begin
         decode_op = alu_ops_pkg::accumulator_plus_file_op;
      end else if (iw[11:6] == `ALU_OP6_AND_FILE) begin
         decode_op = alu_ops_pkg::accumulator_mask_file_op;
      end else if (iw[11:8] == `ALU_OP4_AND_LIT) begin
         decode_op = alu_ops_pkg::accumulator_mask_literal_op;
      end else begin
         decode_op = alu_ops_pkg::op_none;
      end
   endfunction : decode_op

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction : is_zero

   alu_ops_pkg::core_state_t s_q;
   alu_ops_pkg::core_state_t s_d;

   logic                 req;
   logic                 wr_go;
   logic                 exec;
   logic [11:0]          iw;
   alu_ops_pkg::op_t     op;
   logic                 dest_file;
   logic [7:0]           file_rd;
   logic [7:0]           bus_file_rd;
   logic [7:0]           opnd;
   logic [8:0]           sum;
   logic [4:0]           nib;
   logic [7:0]           result;
   logic                 fw_en;
   logic [4:0]           fw_idx;
   logic [7:0]           fw_data;

   //*******************************************************************
   // bus handshake: every access answers one cycle after it appears
   //*******************************************************************
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~s_q.ack;
   assign avs_readdata    = s_q.rdata;
   assign wr_go           = avs_write & s_q.ack;

   // the instruction word needs both low lanes, a single-lane write is dropped
   assign iw   = avs_writedata[11:0];
   assign exec = wr_go && avs_address == `ALU_OFS_INSTR && avs_byteenable[1:0] == 2'h3;
   assign op        = decode_op(iw);
   assign dest_file = iw[`ALU_DEST_BIT];

   file_bank #(
      .DEPTH (32),
      .WIDTH (8)
   ) u_bank (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .wr_en    (fw_en),
      .wr_idx   (fw_idx),
      .wr_data  (fw_data),
      .rd_idx_a (iw[4:0]),
      .rd_a     (file_rd),
      .rd_idx_b (avs_address[6:2]),
      .rd_b     (bus_file_rd)
   );

   //*******************************************************************
   // datapath
   //*******************************************************************
   assign opnd   = (op == alu_ops_pkg::accumulator_mask_literal_op) ? iw[7:0] : file_rd;
   assign sum    = {1'b0, s_q.acc} + {1'b0, opnd};
   assign nib    = {1'b0, s_q.acc[3:0]} + {1'b0, opnd[3:0]};
   assign result = (op == alu_ops_pkg::accumulator_plus_file_op) ? sum[7:0] : (s_q.acc & opnd);

   always_comb begin
      s_d     = s_q;
      fw_en   = 1'b0;
      fw_idx  = avs_address[6:2];
      fw_data = avs_writedata[7:0];
      s_d.ack = req & ~s_q.ack;

      if (avs_read && !s_q.ack) begin
         s_d.rdata = 32'h0000_0000;
         if (avs_address[1:0] != 2'h0) begin
            s_d.rdata = 32'h0000_0000;
         end else if (avs_address[`ALU_FILE_SEL_BIT]) begin
            s_d.rdata[7:0] = bus_file_rd;
         end else begin
            case (avs_address)
               `ALU_OFS_INSTR:  s_d.rdata[11:0] = s_q.last_instr;
               `ALU_OFS_ACC:    s_d.rdata[7:0]  = s_q.acc;
               `ALU_OFS_STATUS: s_d.rdata[3:0]  = {s_q.unsup, s_q.zero, s_q.digit_carry_flag, s_q.carry};
               default:         s_d.rdata       = 32'h0000_0000;
            endcase
         end
      end

      if (wr_go && avs_byteenable[0] && avs_address[1:0] == 2'h0) begin
         if (avs_address[`ALU_FILE_SEL_BIT]) begin
            fw_en = 1'b1;
         end else if (avs_address == `ALU_OFS_ACC) begin
            s_d.acc = avs_writedata[7:0];
         end else if (avs_address == `ALU_OFS_STATUS) begin
            s_d.carry            = avs_writedata[`ALU_ST_CARRY];
            s_d.digit_carry_flag = avs_writedata[`ALU_ST_DIGIT];
            s_d.zero             = avs_writedata[`ALU_ST_ZERO];
            s_d.unsup            = avs_writedata[`ALU_ST_UNSUP];
         end
      end

      // single-cycle execution: state settles at this edge
      if (exec) begin
         s_d.last_instr = iw;
         case (op)
            alu_ops_pkg::accumulator_plus_file_op: begin
               s_d.carry            = sum[8];
               s_d.digit_carry_flag = nib[4];
               s_d.zero             = is_zero(result);
               if (dest_file) begin
                  fw_en   = 1'b1;
                  fw_idx  = iw[4:0];
                  fw_data = result;
               end else begin
                  s_d.acc = result;
               end
            end
            alu_ops_pkg::accumulator_mask_file_op: begin
               s_d.zero = is_zero(result);
               if (dest_file) begin
                  fw_en   = 1'b1;
                  fw_idx  = iw[4:0];
                  fw_data = result;
               end else begin
                  s_d.acc = result;
               end
            end
            alu_ops_pkg::accumulator_mask_literal_op: begin
               s_d.acc  = result;
               s_d.zero = is_zero(result);
            end
            default: begin
               // other opcodes belong to the rest of the core
               s_d.unsup = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_q                  <= '0;
         s_q.acc              <= `ALU_RST_ACC;
         s_q.last_instr       <= `ALU_RST_INSTR;
      end else begin
         s_q <= s_d;
      end
   end

   //*******************************************************************
   // checks
   //*******************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   logic [7:0] file_seen;
   assign file_seen = u_bank.rd_a;

   add_to_acc_a: assert property (exec && op == alu_ops_pkg::accumulator_plus_file_op && !dest_file
      |=> s_q.acc == 8'($past(s_q.acc) + $past(file_rd)))
      else $error("add result not in accumulator");
   add_flags_a: assert property (exec && op == alu_ops_pkg::accumulator_plus_file_op
      |=> s_q.carry == (9'($past(s_q.acc)) + 9'($past(file_rd)) > 9'h0FF)
          && s_q.digit_carry_flag == (5'($past(s_q.acc[3:0])) + 5'($past(file_rd[3:0])) > 5'h0F)
          && s_q.zero == (8'($past(s_q.acc) + $past(file_rd)) == 8'h00))
      else $error("add flags wrong");
   add_to_file_a: assert property (exec && op == alu_ops_pkg::accumulator_plus_file_op && dest_file
      |=> u_bank.s_q.mem[$past(iw[4:0])] == 8'($past(s_q.acc) + $past(file_rd))
          && $stable(s_q.acc))
      else $error("add result not in file");
   and_file_flags_a: assert property (exec && op == alu_ops_pkg::accumulator_mask_file_op
      |=> $stable(s_q.carry) && $stable(s_q.digit_carry_flag)
          && s_q.zero == (($past(s_q.acc) & $past(file_rd)) == 8'h00))
      else $error("and-file flags wrong");
   and_file_dest_a: assert property (exec && op == alu_ops_pkg::accumulator_mask_file_op
      |=> ($past(dest_file)
          ? (u_bank.s_q.mem[$past(iw[4:0])] == ($past(s_q.acc) & $past(file_rd)) && $stable(s_q.acc))
          : (s_q.acc == ($past(s_q.acc) & $past(file_rd)))))
      else $error("and-file destination wrong");
   and_lit_a: assert property (exec && op == alu_ops_pkg::accumulator_mask_literal_op
      |=> s_q.acc == ($past(s_q.acc) & $past(iw[7:0])) && $stable(s_q.carry)
          && s_q.zero == (s_q.acc == 8'h00))
      else $error("and-literal result wrong");
   one_cycle_a: assert property (avs_write && avs_address == `ALU_OFS_INSTR && !s_q.ack
      |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("instruction not taken in one cycle");
   read_answer_a: assert property (avs_read && !s_q.ack && avs_address == `ALU_OFS_ACC
      |=> !avs_waitrequest && avs_readdata == {24'h00_0000, $past(s_q.acc)})
      else $error("accumulator read answer wrong");

   add_cov_c: cover property (exec && op == alu_ops_pkg::accumulator_plus_file_op && sum[8]);
   and_file_cov_c: cover property (exec && op == alu_ops_pkg::accumulator_mask_file_op && dest_file);
   and_lit_cov_c: cover property (exec && op == alu_ops_pkg::accumulator_mask_literal_op
      ##1 exec && op == alu_ops_pkg::accumulator_plus_file_op);
   unused_seen_c: cover property (file_seen == 8'hFF);
endmodule : add_and_alu_ops

// ---- sim/add_and_alu_ops_bench.sv ----
/*
 * self-checking bench for the add/and execution block: corner and random
 * instruction words go in over avalon-mm, results are read back and compared.
 * assumes the block answers every request and needs no other stimulus.
 */
`timescale 1ns/1ps
`include "alu_ops_map.svh"
module add_and_alu_ops_bench;
   logic        mclk;
   logic        rst_n;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   int          n_errors;
   int          checks;
   int          cycles;
   logic [7:0]  acc_m;
   logic [2:0]  st_m;
   logic [7:0]  file_m [32];
   logic [11:0] last_m;

   add_and_alu_ops u_dut (
      .mclk            (mclk),
      .rst_n           (rst_n),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest)
   );

   always #2 mclk = ~mclk;

   //******************************************************************
   // bus and compare tasks
   //******************************************************************
   task automatic report_and_stop();
      if (n_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // one idle edge after release so a following call never re-drives in the same step
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      chk("wait_edges", 32'h0000_0002, n);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge mclk);
   endtask : bus

   //******************************************************************
   // one instruction: preload, execute, read every result back
   //******************************************************************
   task automatic trial(input logic [7:0] a, input logic [4:0] f, input logic [7:0] fv,
                        input logic [2:0] st, input logic [11:0] w);
      logic [31:0] q;
      logic [8:0]  s;
      logic [4:0]  s4;
      bus(1'b1, `ALU_OFS_ACC, {24'h0, a}, q);
      bus(1'b1, {1'b1, f, 2'b00}, {24'h0, fv}, q);
      bus(1'b1, `ALU_OFS_STATUS, {29'h0, st}, q);
      acc_m     = a;
      file_m[f] = fv;
      st_m      = st;
      bus(1'b1, `ALU_OFS_INSTR, {20'h0, w}, q);
      last_m = w;
      s  = {1'b0, acc_m} + {1'b0, file_m[w[4:0]]};
      s4 = {1'b0, acc_m[3:0]} + {1'b0, file_m[w[4:0]][3:0]};
      if (w[11:6] == 6'h07) begin
         st_m = {s[7:0] == 8'h00, s4[4], s[8]};
         if (w[5]) file_m[w[4:0]] = s[7:0];
         else acc_m = s[7:0];
      end else if (w[11:6] == 6'h05) begin
         s[7:0] = acc_m & file_m[w[4:0]];
         st_m[2] = (s[7:0] == 8'h00);
         if (w[5]) file_m[w[4:0]] = s[7:0];
         else acc_m = s[7:0];
      end else begin
         acc_m   = acc_m & w[7:0];
         st_m[2] = (acc_m == 8'h00);
      end
      bus(1'b0, `ALU_OFS_ACC, 32'h0, q);
      chk("acc", {24'h0, acc_m}, q);
      bus(1'b0, `ALU_OFS_STATUS, 32'h0, q);
      chk("status", {29'h0, st_m}, q);
      bus(1'b0, {1'b1, w[4:0], 2'b00}, 32'h0, q);
      chk("file", {24'h0, file_m[w[4:0]]}, q);
      bus(1'b0, `ALU_OFS_INSTR, 32'h0, q);
      chk("last_instr", {20'h0, last_m}, q);
   endtask : trial

   always @(posedge mclk) begin
      cycles++;
      if (cycles >= 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   //******************************************************************
   // main sequence
   //******************************************************************
   initial begin
      logic [31:0] q;
      logic [4:0]  f;
      logic        d;
      mclk = 1'b0;
      rst_n = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      n_errors = 0;
      checks = 0;
      cycles = 0;
      q = $urandom(10934);
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      bus(1'b0, `ALU_OFS_ACC, 32'h0, q);
      chk("acc_reset", 32'h0, q);
      bus(1'b0, `ALU_OFS_STATUS, 32'h0, q);
      chk("status_reset", 32'h0, q);
      bus(1'b0, 8'h40, 32'h0, q);
      chk("unmapped", 32'h0, q);
      // refused accesses leave state alone; an unknown opcode sets the sticky bit and last_instr, nothing else
      bus(1'b1, `ALU_OFS_ACC, 32'h0000_003C, q);
      avs_byteenable <= 4'h1;
      bus(1'b1, `ALU_OFS_INSTR, 32'h0000_0E0F, q);
      avs_byteenable <= 4'hF;
      bus(1'b1, 8'h05, 32'h0000_00FF, q);
      bus(1'b0, `ALU_OFS_ACC, 32'h0, q);
      chk("acc_refused", 32'h0000_003C, q);
      bus(1'b0, `ALU_OFS_INSTR, 32'h0, q);
      chk("instr_refused", 32'h0, q);
      bus(1'b0, 8'h05, 32'h0, q);
      chk("unaligned", 32'h0, q);
      bus(1'b1, `ALU_OFS_INSTR, 32'h0000_03C5, q);
      bus(1'b0, `ALU_OFS_STATUS, 32'h0, q);
      chk("unsup_set", 32'h0000_0008, q);
      bus(1'b0, `ALU_OFS_ACC, 32'h0, q);
      chk("acc_unsup", 32'h0000_003C, q);
      bus(1'b0, `ALU_OFS_INSTR, 32'h0, q);
      chk("instr_unsup", 32'h0000_03C5, q);
      // corner cases: worked examples, carry/digit/zero edges, flags kept by and
      trial(8'h17, 5'h04, 8'hC2, 3'h0, {6'h07, 1'b0, 5'h04});
      trial(8'h17, 5'h04, 8'hC2, 3'h3, {6'h05, 1'b1, 5'h04});
      trial(8'hA3, 5'h00, 8'h11, 3'h3, {4'hE, 8'h5F});
      trial(8'hFF, 5'h00, 8'h01, 3'h0, {6'h07, 1'b1, 5'h00});
      trial(8'h0F, 5'h1F, 8'h01, 3'h4, {6'h07, 1'b0, 5'h1F});
      trial(8'hF0, 5'h1F, 8'h0F, 3'h3, {6'h05, 1'b0, 5'h1F});
      trial(8'h5A, 5'h02, 8'h00, 3'h7, {4'hE, 8'hA5});
      repeat (300) begin
         f = 5'($urandom);
         d = 1'($urandom);
         case ($urandom_range(2, 0))
            0: trial(8'($urandom), f, 8'($urandom), 3'($urandom), {6'h07, d, f});
            1: trial(8'($urandom), f, 8'($urandom), 3'($urandom), {6'h05, d, f});
            default: trial(8'($urandom), f, 8'($urandom), 3'($urandom), {4'hE, 8'($urandom)});
         endcase
      end
      report_and_stop();
   end
endmodule : add_and_alu_ops_bench
